// [verilog/ssw_top.sv]
// Supply supervisor core: reset sequencer, watchdog and Avalon registers.
// Functional notes
// [RULE_01] Reset output stays low a full hold time after causes clear.
// [RULE_02] Supply below trip drives the reset output low.
// [RULE_03] Hold starts only once supply exceeds trip plus hysteresis.
// [RULE_04] Manual reset low holds reset, then a hold time follows.
// [RULE_05] Manual low of one microsecond always gives a reset.
// [RULE_06] Manual input is filtered so a bare switch can drive it.
// [RULE_07] Board must tie manual input; there is no internal pull-up.
// [RULE_08] Processor kicks within each timeout, else a reset pulse.
// [RULE_09] Watchdog fault gives a reset pulse of the hold time.
// [RULE_10] Kick falling edge or asserted reset clears the watchdog count.
// [RULE_11] Kick pulses of 150 ns are detected.
// [RULE_12] Range select low uses the basic timeout.
// [RULE_13] Range select high multiplies the basic timeout by 128.
// [RULE_14] Any range select change clears the watchdog count.
// [RULE_15] Grounded capacitor pin disables the watchdog entirely.
// [RULE_16] Timeout is whole 6.4 ms ticks plus a 3.2 ms half tick.
// [RULE_17] Internal tick nominal 6.4 ms, tolerated 3.5 to 9.5 ms.
// [RULE_18] Watchdog count stays zero during reset, resumes at release.
// [RULE_19] Timeout sampled after release; aborted and restarted by reset.
// [RULE_20] Zero sample holds reset (here: a reset pulse follows each sample instead); overrange sample disables watchdog.
// [RULE_21] Supply compare is a synchronous input; times are tick counts.
// [RULE_22] Kick, manual and range inputs are synchronised first.
module ssw_top #(
  parameter int unsigned HALF_TICK_CYC = ssw_pkg::HALF_TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Supply comparator
  input  wire logic        supply_below_trip,
  input  wire logic        supply_above_hyst,
  // Processor pins
  input  wire logic        manual_reset_n,
  input  wire logic        wdog_kick_in,
  input  wire logic        timeout_range_select,
  // Watchdog capacitor sensing
  input  wire logic        wdog_cap_grounded,
  input  wire logic [15:0] wdog_cap_ticks,
  // Reset output
  output logic             reset_out_n
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  ssw_pkg::ssw_state_t state_reg;
  ssw_pkg::ssw_state_t state_next;
  logic                mr_level;
  logic                kick_fall;
  logic                wds_level;
  logic                wds_change;
  logic                cause;
  logic [16:0]         hold_cnt_reg;
  logic                hold_done;
  logic [23:0]         wd_cnt_reg;
  logic [23:0]         wd_limit;
  logic                wd_clear;
  logic                wd_off;
  logic                wdog_fault;
  logic [6:0]          samp_cnt_reg;
  logic                samp_done_reg;
  logic [15:0]         timeout_reg;
  logic [15:0]         hold_ticks_reg;
  logic                fault_seen_reg;
  logic                bus_req;
  logic                bus_wr;

  ssw_tick_if tick_bus ();

  // -----------------------------------------------------------------------
  // Input conditioning
  // -----------------------------------------------------------------------
  // [RULE_05] [RULE_06] Manual glitch filter.
  // [RULE_07] Manual input assumed driven.
  ssw_in_filter #(
    .STABLE_CYC   (ssw_pkg::MR_STABLE_CYC),
    .RST_LEVEL    (1'b1)
  ) u_mr_filt (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (manual_reset_n),
    .level_out    (mr_level),
    .fall_pulse   (),
    .change_pulse ()
  );

  // [RULE_11] [RULE_22] Short kick detection.
  ssw_in_filter #(
    .STABLE_CYC   (ssw_pkg::KICK_STABLE_CYC),
    .RST_LEVEL    (1'b1)
  ) u_kick_filt (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (wdog_kick_in),
    .level_out    (),
    .fall_pulse   (kick_fall),
    .change_pulse ()
  );

  // [RULE_22] Range select synchroniser.
  ssw_in_filter #(
    .STABLE_CYC   (ssw_pkg::WDS_STABLE_CYC),
    .RST_LEVEL    (1'b0)
  ) u_wds_filt (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (timeout_range_select),
    .level_out    (wds_level),
    .fall_pulse   (),
    .change_pulse (wds_change)
  );

  // [RULE_17] Internal tick source.
  ssw_tick_gen #(
    .HALF_CYC (HALF_TICK_CYC)
  ) u_tick (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .tk       (tick_bus)
  );

  // -----------------------------------------------------------------------
  // Reset sequencer
  // -----------------------------------------------------------------------
  // [RULE_02] [RULE_04] [RULE_21] Reset causes.
  assign cause = supply_below_trip || !mr_level;

  // [RULE_01] Hold length in half ticks.
  assign hold_done = (hold_cnt_reg >= {hold_ticks_reg, 1'b0});

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ssw_pkg::SSW_ASSERT: begin
        // [RULE_03] Release needs hysteresis.
        if (!cause && supply_above_hyst) begin
          state_next = ssw_pkg::SSW_HOLD;
        end
      end
      ssw_pkg::SSW_HOLD: begin
        if (cause) begin
          state_next = ssw_pkg::SSW_ASSERT;
        end else if (hold_done) begin
          state_next = ssw_pkg::SSW_RUN;
        end
      end
      ssw_pkg::SSW_RUN: begin
        if (cause) begin
          state_next = ssw_pkg::SSW_ASSERT;
        // [RULE_08] [RULE_09] Fault starts a pulse.
        end else if (wdog_fault) begin
          state_next = ssw_pkg::SSW_HOLD;
        end
      end
      default: begin
        state_next = ssw_pkg::SSW_ASSERT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= ssw_pkg::SSW_ASSERT;
      reset_out_n <= 1'b0;
    end else begin
      state_reg   <= state_next;
      reset_out_n <= (state_next == ssw_pkg::SSW_RUN);
    end
  end

  // The prescaler restarts at every state change so that holds and
  // timeouts are measured from their true start.
  // Outside RUN the watchdog clear is held, so only run-time kicks and
  // range changes may restart it; otherwise holds would never tick.
  assign tick_bus.restart = (state_next != state_reg) ||
                            ((state_reg == ssw_pkg::SSW_RUN) && wd_clear);

  // [RULE_01] Hold counter.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= 17'h00000;
    end else if (state_reg != ssw_pkg::SSW_HOLD) begin
      hold_cnt_reg <= 17'h00000;
    end else if (tick_bus.half_tick && !hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + 17'h00001;
    end
  end

  // -----------------------------------------------------------------------
  // Timeout sampling
  // -----------------------------------------------------------------------
  // [RULE_19] Sample after release, abort on reset.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_reg  <= 7'h00;
      samp_done_reg <= 1'b0;
      timeout_reg   <= ssw_pkg::CAP_ZERO;
    end else if (state_reg != ssw_pkg::SSW_RUN) begin
      samp_cnt_reg  <= 7'h00;
      samp_done_reg <= 1'b0;
    end else if (!samp_done_reg) begin
      if (samp_cnt_reg == ssw_pkg::SAMPLE_LAST) begin
        samp_done_reg <= 1'b1;
        timeout_reg   <= wdog_cap_ticks;
      end else begin
        samp_cnt_reg <= samp_cnt_reg + 7'h01;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Watchdog
  // -----------------------------------------------------------------------
  // [RULE_10] [RULE_14] [RULE_18] Count clear sources.
  assign wd_clear = (state_reg != ssw_pkg::SSW_RUN) || kick_fall ||
                    wds_change;

  // [RULE_15] [RULE_20] Watchdog disable.
  assign wd_off = wdog_cap_grounded || (timeout_reg == ssw_pkg::CAP_INFINITE);

  always_comb begin
    // [RULE_16] [RULE_20] Whole ticks plus half tick, or zero.
    if (timeout_reg == ssw_pkg::CAP_ZERO) begin
      wd_limit = 24'h000000;
    end else if (wds_level) begin
      // [RULE_13] Extended mode.
      wd_limit = {timeout_reg, 1'b1, 7'h00};
    end else begin
      // [RULE_12] Normal mode.
      wd_limit = {7'h00, timeout_reg, 1'b1};
    end
  end

  // [RULE_08] Timeout detection.
  assign wdog_fault = (state_reg == ssw_pkg::SSW_RUN) && samp_done_reg &&
                      !wd_off && !wd_clear && (wd_cnt_reg >= wd_limit);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_reg <= 24'h000000;
    // [RULE_10] [RULE_18] Clear and hold at zero.
    end else if (wd_clear) begin
      wd_cnt_reg <= 24'h000000;
    end else if (tick_bus.half_tick && (wd_cnt_reg != 24'hFFFFFF)) begin
      wd_cnt_reg <= wd_cnt_reg + 24'h000001;
    end
  end

  // -----------------------------------------------------------------------
  // Avalon-MM register slave
  // -----------------------------------------------------------------------
  // Every access is answered one cycle after it is seen.
  assign bus_req = (avs_read || avs_write) && avs_waitrequest;
  assign bus_wr  = avs_write && avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= !bus_req;
      if (bus_req && avs_read) begin
        unique case (avs_address)
          ssw_pkg::ADDR_HOLD:    avs_readdata <= {16'h0000, hold_ticks_reg};
          ssw_pkg::ADDR_STATUS: begin
            avs_readdata <= 32'h00000000;
            avs_readdata[ssw_pkg::ST_BIT_RUN]     <= reset_out_n;
            avs_readdata[ssw_pkg::ST_BIT_WD_ON]   <= !wd_off;
            avs_readdata[ssw_pkg::ST_BIT_SAMPLED] <= samp_done_reg;
            avs_readdata[ssw_pkg::ST_BIT_FAULT]   <= fault_seen_reg;
            avs_readdata[ssw_pkg::ST_BIT_EXT]     <= wds_level;
          end
          ssw_pkg::ADDR_COUNT:   avs_readdata <= {8'h00, wd_cnt_reg};
          ssw_pkg::ADDR_TIMEOUT: avs_readdata <= {16'h0000, timeout_reg};
          default:               avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // [RULE_21] Hold time in ticks, software adjustable.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_ticks_reg <= ssw_pkg::HOLD_TICKS_RST;
    end else if (bus_wr && (avs_address == ssw_pkg::ADDR_HOLD)) begin
      if (avs_byteenable[0]) begin
        hold_ticks_reg[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        hold_ticks_reg[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // Sticky fault flag, write one to clear; a new fault wins.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_seen_reg <= 1'b0;
    end else if (wdog_fault) begin
      fault_seen_reg <= 1'b1;
    end else if (bus_wr && (avs_address == ssw_pkg::ADDR_STATUS) &&
                 avs_byteenable[0] &&
                 avs_writedata[ssw_pkg::ST_BIT_FAULT]) begin
      fault_seen_reg <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_supply_low;
    @(posedge clk_sys) disable iff (!rst_n)
    supply_below_trip |=> !reset_out_n;
  endproperty
  a_supply_low: assert property (p_supply_low) // RULE_02
    else $error("Reset not asserted on low supply.");

  property p_hysteresis;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == ssw_pkg::SSW_ASSERT && !supply_above_hyst)
      |=> (state_reg == ssw_pkg::SSW_ASSERT);
  endproperty
  a_hysteresis: assert property (p_hysteresis) // RULE_03
    else $error("Hold began below trip plus hysteresis.");

  property p_release_after_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(reset_out_n) |-> ($past(state_reg) == ssw_pkg::SSW_HOLD) &&
      ($past(hold_cnt_reg) >= {$past(hold_ticks_reg), 1'b0});
  endproperty
  a_release_after_hold: assert property (p_release_after_hold) // RULE_01
    else $error("Reset released before the hold time.");

  property p_manual_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    !mr_level |=> !reset_out_n [*2];
  endproperty
  a_manual_hold: assert property (p_manual_hold) // RULE_04
    else $error("Reset released while manual reset low.");

  property p_count_cleared;
    @(posedge clk_sys) disable iff (!rst_n)
    (!reset_out_n || kick_fall) |=> (wd_cnt_reg == 24'h000000);
  endproperty
  a_count_cleared: assert property (p_count_cleared) // RULE_10
    else $error("Watchdog count not cleared.");

  property p_range_change;
    @(posedge clk_sys) disable iff (!rst_n)
    wds_change |=> (wd_cnt_reg == 24'h000000);
  endproperty
  a_range_change: assert property (p_range_change) // RULE_14
    else $error("Range change did not clear the count.");

  property p_fault_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
    wdog_fault |=> !reset_out_n && (state_reg == ssw_pkg::SSW_HOLD);
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) // RULE_09
    else $error("Watchdog fault did not start a reset pulse.");

  property p_grounded_off;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == ssw_pkg::SSW_RUN && wdog_cap_grounded && !cause)
      |=> (state_reg == ssw_pkg::SSW_RUN);
  endproperty
  a_grounded_off: assert property (p_grounded_off) // RULE_15
    else $error("Watchdog reset with grounded capacitor pin.");

  property p_sample_abort;
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg != ssw_pkg::SSW_RUN) |=> !samp_done_reg;
  endproperty
  a_sample_abort: assert property (p_sample_abort) // RULE_19
    else $error("Sampling not aborted by reset.");

  property p_ext_limit;
    @(posedge clk_sys) disable iff (!rst_n)
    (wds_level && timeout_reg != ssw_pkg::CAP_ZERO)
      |-> (wd_limit == 24'((32'(timeout_reg) * 32'h2 + 32'h1) * 32'h80));
  endproperty
  a_ext_limit: assert property (p_ext_limit) // RULE_13
    else $error("Extended limit not scaled by 128.");

  property p_bus_answer;
    @(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus access not answered in one cycle.");

  c_wdog_fault: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_fault);
  c_manual_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n)
    !mr_level ##[1:1000] $rose(reset_out_n));
  c_ext_fault: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_fault && wds_level);
  c_kick: cover property (@(posedge clk_sys) disable iff (!rst_n)
    kick_fall && reset_out_n);

endmodule // ssw_top

// [verilog/ssw_pkg.sv]
// Shared constants and types of the supply supervisor with watchdog.
package ssw_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned TICK_PERIOD_US   = 6400;
  localparam int unsigned HALF_TICK_US     = 3200;
  localparam int unsigned TICK_MIN_US      = 3500;
  localparam int unsigned TICK_MAX_US      = 9500;
  localparam int unsigned HALF_TICK_CYC    =
    HALF_TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned KICK_MIN_NS      = 150;
  localparam int unsigned KICK_MIN_CYC     = KICK_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned KICK_STABLE_CYC  = 1;
  localparam int unsigned MR_GLITCH_NS     = 200;
  localparam int unsigned MR_STABLE_CYC    =
    (MR_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MR_MIN_NS        = 1000;
  localparam int unsigned MR_MIN_CYC       =
    (MR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDS_STABLE_CYC   = 1;
  localparam logic [6:0]  SAMPLE_LAST      = 7'h3F;

  // ---------------------------------------------------------------------
  // Watchdog timeout encoding
  // ---------------------------------------------------------------------
  localparam logic [15:0] CAP_ZERO         = 16'h0000;
  localparam logic [15:0] CAP_INFINITE     = 16'hFFFF;
  localparam int unsigned EXT_SHIFT        = 7;

  // ---------------------------------------------------------------------
  // Register map (word index on the Avalon address)
  // ---------------------------------------------------------------------
  localparam logic [2:0]  ADDR_HOLD        = 3'h0;
  localparam logic [2:0]  ADDR_STATUS      = 3'h1;
  localparam logic [2:0]  ADDR_COUNT       = 3'h2;
  localparam logic [2:0]  ADDR_TIMEOUT     = 3'h3;
  localparam logic [15:0] HOLD_TICKS_RST   = 16'h0003;
  localparam int unsigned ST_BIT_RUN       = 0;
  localparam int unsigned ST_BIT_WD_ON     = 1;
  localparam int unsigned ST_BIT_SAMPLED   = 2;
  localparam int unsigned ST_BIT_FAULT     = 3;
  localparam int unsigned ST_BIT_EXT       = 4;

  // ---------------------------------------------------------------------
  // Reset sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSW_ASSERT = 2'b00,
    SSW_HOLD   = 2'b01,
    SSW_RUN    = 2'b11
  } ssw_state_t;

endpackage

// [verilog/ssw_tick_if.sv]
// Tick carrier between the supervisor core and its tick generator.
interface ssw_tick_if;
  logic restart;
  logic half_tick;
  modport gen  (input restart, output half_tick);
  modport user (output restart, input half_tick);
endinterface

// [verilog/ssw_in_filter.sv]
// Three-flop synchroniser with stability filter and edge pulses.
module ssw_in_filter #(
  parameter int unsigned STABLE_CYC = 1,
  parameter logic        RST_LEVEL  = 1'b1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin_in,
  // Filtered side
  output logic      level_out,
  output logic      fall_pulse,
  output logic      change_pulse
);

  logic [2:0] sync_reg;
  logic [3:0] stable_reg;
  logic       differ;

  assign differ = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_out);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg <= {3{RST_LEVEL}};
    end else begin
      sync_reg <= {sync_reg[1:0], pin_in};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stable_reg   <= 4'h0;
      level_out    <= RST_LEVEL;
      fall_pulse   <= 1'b0;
      change_pulse <= 1'b0;
    end else begin
      fall_pulse   <= 1'b0;
      change_pulse <= 1'b0;
      if (!differ) begin
        stable_reg <= 4'h0;
      end else if (stable_reg == 4'(STABLE_CYC - 1)) begin
        stable_reg   <= 4'h0;
        level_out    <= sync_reg[2];
        fall_pulse   <= !sync_reg[2];
        change_pulse <= 1'b1;
      end else begin
        stable_reg <= stable_reg + 4'h1;
      end
    end
  end

endmodule // ssw_in_filter

// [verilog/ssw_tick_gen.sv]
// Half-tick prescaler of the internal watchdog clock.
module ssw_tick_gen #(
  parameter int unsigned HALF_CYC = ssw_pkg::HALF_TICK_CYC
) (
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  // Tick carrier
  ssw_tick_if.gen    tk
);

  localparam int unsigned W = $clog2(HALF_CYC + 1);

  logic [W-1:0] cnt_reg;
  logic         pulse_reg;

  assign tk.half_tick = pulse_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else if (tk.restart) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else if (cnt_reg == W'(HALF_CYC - 1)) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b1;
    end else begin
      cnt_reg   <= cnt_reg + W'(1);
      pulse_reg <= 1'b0;
    end
  end

endmodule // ssw_tick_gen

// [verification/ssw_cpu_model.sv]
// Processor model that kicks the watchdog while it is out of reset.
module ssw_cpu_model #(
  parameter int GAP = 40,
  parameter int LOW = 6
) (
  // Clock and control
  input  wire logic clk_sys,
  input  wire logic kick_en,
  // Device pins
  input  wire logic reset_out_n,
  output logic      wdog_kick_in
);
  timeunit 1ns;
  timeprecision 1ps;

  int cnt_reg = 0;

  initial wdog_kick_in = 1'b1;

  always @(posedge clk_sys) begin
    if (!reset_out_n || !kick_en) begin
      cnt_reg      <= 0;
      wdog_kick_in <= 1'b1;
    end else begin
      cnt_reg      <= (cnt_reg == GAP - 1) ? 0 : cnt_reg + 1;
      wdog_kick_in <= (cnt_reg >= GAP - LOW) ? 1'b0 : 1'b1;
    end
  end
endmodule // ssw_cpu_model

// [verification/ssw_top_bench.sv]
// Self-checking bench of the supervisor with watchdog.
module ssw_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 20;
  localparam int HC   = 2 * 2 * HALF;

  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [2:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        supply_below_trip, supply_above_hyst, manual_reset_n;
  logic        wdog_kick_in, timeout_range_select, wdog_cap_grounded;
  logic        reset_out_n, kick_en;
  logic [15:0] wdog_cap_ticks;
  int          n_fail = 0, compares = 0, cyc_cnt = 0, n;

  ssw_top #(.HALF_TICK_CYC(HALF)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_below_trip(supply_below_trip),
    .supply_above_hyst(supply_above_hyst),
    .manual_reset_n(manual_reset_n), .wdog_kick_in(wdog_kick_in),
    .timeout_range_select(timeout_range_select),
    .wdog_cap_grounded(wdog_cap_grounded),
    .wdog_cap_ticks(wdog_cap_ticks), .reset_out_n(reset_out_n));

  ssw_cpu_model cpu (.clk_sys(clk_sys), .kick_en(kick_en),
    .reset_out_n(reset_out_n), .wdog_kick_in(wdog_kick_in));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      n_fail = n_fail + 1;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares = compares + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic avs_rd(input logic [2:0] a);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic avs_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wait_lvl(input logic v, input int lim);
    n = 0;
    while (reset_out_n !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  initial begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 3'h0; avs_writedata = 32'h0; avs_byteenable = 4'hF;
    supply_below_trip = 1'b1; supply_above_hyst = 1'b0;
    manual_reset_n = 1'b1; timeout_range_select = 1'b0;
    wdog_cap_grounded = 1'b0; wdog_cap_ticks = 16'h0002; kick_en = 1'b1;
    cyc(12);
    rst_n <= 1'b1;
    avs_rd(ssw_pkg::ADDR_HOLD);
    chk("hold_rst", rd, {16'h0, ssw_pkg::HOLD_TICKS_RST});
    avs_rd(3'h7);
    chk("unmapped", rd, 32'h0);
    avs_wr(ssw_pkg::ADDR_HOLD, 32'h0000_0002);
    avs_rd(ssw_pkg::ADDR_HOLD);
    chk("hold_rw", rd, 32'h0000_0002);
    avs_byteenable <= 4'h1;
    avs_wr(ssw_pkg::ADDR_HOLD, 32'h0000_AB02);
    avs_byteenable <= 4'hF;
    avs_rd(ssw_pkg::ADDR_HOLD);
    chk("hold_be", rd, 32'h0000_0002);
    supply_below_trip <= 1'b0;
    cyc(200);
    chk("hyst_wait", reset_out_n, 1'b0);
    supply_above_hyst <= 1'b1;
    wait_lvl(1'b1, 400);
    chk("hold_len", n >= HC && n <= HC + 10, 1'b1);
    cyc(600);
    chk("kicked", reset_out_n, 1'b1);
    $display("test power_up done");
    kick_en <= 1'b0;
    wait_lvl(1'b0, 300);
    chk("wd_time", n >= 40 && n <= 130, 1'b1);
    wait_lvl(1'b1, 400);
    chk("wd_pulse", n >= HC && n <= HC + 10, 1'b1);
    avs_rd(ssw_pkg::ADDR_STATUS);
    chk("fault", rd[ssw_pkg::ST_BIT_FAULT], 1'b1);
    chk("st_run", rd[ssw_pkg::ST_BIT_RUN], 1'b1);
    chk("st_wd_on", rd[ssw_pkg::ST_BIT_WD_ON], 1'b1);
    chk("st_sampling", rd[ssw_pkg::ST_BIT_SAMPLED], 1'b0);
    avs_wr(ssw_pkg::ADDR_STATUS, 32'h0000_0008);
    avs_rd(ssw_pkg::ADDR_STATUS);
    chk("fault_clr", rd[ssw_pkg::ST_BIT_FAULT], 1'b0);
    $display("test watchdog done");
    kick_en <= 1'b1;
    manual_reset_n <= 1'b0;
    cyc(4);
    manual_reset_n <= 1'b1;
    cyc(40);
    chk("glitch", reset_out_n, 1'b1);
    manual_reset_n <= 1'b0;
    cyc(40);
    chk("mr_1us", reset_out_n, 1'b0);
    cyc(200);
    chk("mr_held", reset_out_n, 1'b0);
    manual_reset_n <= 1'b1;
    wait_lvl(1'b1, 400);
    chk("mr_hold", n >= HC && n <= HC + 20, 1'b1);
    $display("test manual done");
    supply_below_trip <= 1'b1;
    supply_above_hyst <= 1'b0;
    cyc(3);
    chk("brownout", reset_out_n, 1'b0);
    supply_below_trip <= 1'b0;
    supply_above_hyst <= 1'b1;
    wait_lvl(1'b1, 400);
    $display("test brownout done");
    kick_en <= 1'b0;
    timeout_range_select <= 1'b1;
    cyc(1000);
    chk("extended", reset_out_n, 1'b1);
    avs_rd(ssw_pkg::ADDR_STATUS);
    chk("st_ext", rd[ssw_pkg::ST_BIT_EXT], 1'b1);
    timeout_range_select <= 1'b0;
    wait_lvl(1'b0, 300);
    chk("normal", n >= 80 && n <= 130, 1'b1);
    wait_lvl(1'b1, 400);
    wdog_cap_grounded <= 1'b1;
    cyc(1000);
    chk("grounded", reset_out_n, 1'b1);
    avs_rd(ssw_pkg::ADDR_STATUS);
    chk("st_wd_off", rd[ssw_pkg::ST_BIT_WD_ON], 1'b0);
    avs_rd(ssw_pkg::ADDR_COUNT);
    chk("count", rd >= 32'h30 && rd <= 32'h34, 1'b1);
    avs_rd(ssw_pkg::ADDR_TIMEOUT);
    chk("timeout", rd, 32'h0000_0002);
    $display("test range done");
    wdog_cap_ticks <= 16'h0000;
    wdog_cap_grounded <= 1'b0;
    wait_lvl(1'b0, 300);
    wait_lvl(1'b1, 400);
    wait_lvl(1'b0, 100);
    chk("zero_cap", n >= 60 && n <= 80, 1'b1);
    wdog_cap_ticks <= 16'hFFFF;
    wait_lvl(1'b1, 400);
    cyc(1000);
    chk("inf_cap", reset_out_n, 1'b1);
    avs_rd(ssw_pkg::ADDR_TIMEOUT);
    chk("timeout_inf", rd, 32'h0000_FFFF);
    $display("test zero_sample done");
    close_out();
  end
endmodule // ssw_top_bench
